// [die_regs.vh]
`ifndef DIE_REGS_VH
`define DIE_REGS_VH

// Register addresses on the serial control port back end
`define DIE_ADDR_W          13
`define DIE_ADDR_EN_FIRST   13'h020
`define DIE_ADDR_EN_SECOND  13'h021
`define DIE_ADDR_ST_FIRST   13'h024
`define DIE_ADDR_ST_SECOND  13'h025

// Reset values
`define DIE_EN_RST          8'h00

// Bits of the second enable register that hold storage (6:5 reserved)
`define DIE_EN_SECOND_MASK  8'h9F

// Bits of each status register served by this block
`define DIE_ST_FIRST_MASK   8'h3B
`define DIE_ST_SECOND_MASK  8'h9F

// Field positions, first enable/status register
`define DIE_BIT_DLYBUF      5
`define DIE_BIT_DATARDY     4
`define DIE_BIT_OVERFLOW    3
`define DIE_BIT_QPRBS       1
`define DIE_BIT_IPRBS       0

// Field positions, second enable/status register
`define DIE_BIT_PWRDET      7
`define DIE_BIT_OSCALIGN    4
`define DIE_BIT_LOCK        3
`define DIE_BIT_ROTATE      2
`define DIE_BIT_WINDOW      1
`define DIE_BIT_TRIP        0

`endif

// [die_event_cell.v]
`timescale 1ns/1ps
`default_nettype none

// One event: live view while disabled, rising-edge latch while enabled
module die_event_cell (
    // Clock and reset
    input  wire clk_sys_i,
    input  wire resetn_i,
    // Control
    input  wire enable_i,
    input  wire live_i,
    input  wire clear_i,
    // Result
    output wire status_o,
    output wire latched_o
);

    reg live_d_ff;
    reg lat_ff;
    wire rise;
    wire nxt_lat;

    assign rise = live_i & ~live_d_ff;
    // Set wins over a write-one clear in the same cycle; disabling drops
    // the latch so a later enable starts clean
    assign nxt_lat = enable_i & (rise | (lat_ff & ~clear_i));

    // Edge history and latch
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            live_d_ff <= 1'b0;
            lat_ff    <= 1'b0;
        end else begin
            live_d_ff <= live_i;
            lat_ff    <= nxt_lat;
        end
    end

    assign status_o  = enable_i ? lat_ff : live_i;
    assign latched_o = lat_ff;

endmodule // die_event_cell

`default_nettype wire

// [die_irq_enable.v]
`timescale 1ns/1ps
`default_nettype none
`include "die_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - Bit 4 first enable: data-ready event latches, pulls interrupt low.
// - Data-ready disabled: status follows live condition, no interrupt.
// - Bit 3 first enable: any datapath overflow latches, pulls low.
// - Bit 1 first enable: Q PRBS event latches, pulls interrupt low.
// - Bit 0 first enable: I PRBS event latches, pulls interrupt low.
// - Delay-buffer disabled: status shows present buffer state, no interrupt.
// - Bit 7 second enable at 0x021: power-detect error latches, pulls low.
// - Second enable bits 6:5 reserved, read zero, no effect.
// - Bit 4 second enable: oscillator alignment event latches, pulls low.
// - Bit 3 second enable: lock event latches; disabled shows live lock.
// - Bit 2 second enable: rotate event latches; disabled shows live.
// - Bit 1 second enable: out-of-window event latches, pulls low.
// - Bit 0 second enable: trip latches; disabled shows live trip.
module die_irq_enable (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    // Register port from the serial control interface
    input  wire [12:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    output wire [7:0]  reg_rdata_o,
    // Live event conditions, same clock
    input  wire        delay_buffer_evt_i,
    input  wire        data_ready_evt_i,
    input  wire        datapath_overflow_evt_i,
    input  wire        q_prbs_evt_i,
    input  wire        i_prbs_evt_i,
    input  wire        power_detect_err_evt_i,
    input  wire        osc_align_evt_i,
    input  wire        link_align_lock_evt_i,
    input  wire        link_align_rotate_evt_i,
    input  wire        link_align_window_evt_i,
    input  wire        link_align_tripped_i,
    // Interrupt to host
    output wire        irq_n_o
);

    // Register map served here; status bits sit where their enables sit
    //   0x020 enable first   5 delay buffer, 4 data ready, 3 overflow,
    //                        1 Q PRBS, 0 I PRBS; 7, 6 and 2 only store
    //   0x021 enable second  7 power detect, 4 oscillator alignment,
    //                        3 lock, 2 rotate, 1 window, 0 trip
    //                        6:5 never store and read zero
    //   0x024 status first   live view or latch, write one clears
    //   0x025 status second  same rules, second byte of events
    // Reads are always on and registered: data lags the address by one
    // edge and there is no read strobe to qualify.
    // A latch needs a fresh rising edge while enabled, so an event that is
    // already high when software enables it stays silent until it recurs.

    reg  [7:0]  en_first_ff;
    reg  [7:0]  en_second_ff;
    reg  [7:0]  rdata_ff;
    reg  [7:0]  nxt_rdata;
    reg         irq_n_ff;
    wire        wr_en1;
    wire        wr_en2;
    wire        wr_st1;
    wire        wr_st2;
    wire [15:0] en_all;
    wire [15:0] live_all;
    wire [15:0] clr_all;
    wire [15:0] status_all;
    wire [15:0] latched_all;
    wire        irq_any;
    reg  [7:0]  en_first_vec;
    reg  [7:0]  en_second_vec;
    reg  [7:0]  live_first;
    reg  [7:0]  live_second;
    wire        delay_buffer_int_en;
    wire        data_ready_int_en;
    wire        datapath_overflow_int_en;
    wire        q_prbs_int_en;
    wire        i_prbs_int_en;
    wire        power_detect_err_int_en;
    wire        osc_align_int_en;
    wire        link_align_lock_int_en;
    wire        link_align_rotate_int_en;
    wire        link_align_window_int_en;
    wire        link_align_trip_int_en;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_en1 = reg_wr_i & (reg_addr_i == `DIE_ADDR_EN_FIRST);
    assign wr_en2 = reg_wr_i & (reg_addr_i == `DIE_ADDR_EN_SECOND);
    assign wr_st1 = reg_wr_i & (reg_addr_i == `DIE_ADDR_ST_FIRST);
    assign wr_st2 = reg_wr_i & (reg_addr_i == `DIE_ADDR_ST_SECOND);

    // Enable registers; reserved bits of the second never store
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_first_ff  <= `DIE_EN_RST;
            en_second_ff <= `DIE_EN_RST;
        end else begin
            if (wr_en1) begin
                en_first_ff <= reg_wdata_i;
            end
            if (wr_en2) begin
                en_second_ff <= reg_wdata_i & `DIE_EN_SECOND_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event vectors, second register in the upper byte
    // Named enable bits; positions we do not serve stay zero below, so
    // their cells can never latch whatever software stores there
    assign delay_buffer_int_en      = en_first_ff[`DIE_BIT_DLYBUF];
    assign data_ready_int_en        = en_first_ff[`DIE_BIT_DATARDY];
    assign datapath_overflow_int_en = en_first_ff[`DIE_BIT_OVERFLOW];
    assign q_prbs_int_en            = en_first_ff[`DIE_BIT_QPRBS];
    assign i_prbs_int_en            = en_first_ff[`DIE_BIT_IPRBS];
    assign power_detect_err_int_en  = en_second_ff[`DIE_BIT_PWRDET];
    assign osc_align_int_en         = en_second_ff[`DIE_BIT_OSCALIGN];
    assign link_align_lock_int_en   = en_second_ff[`DIE_BIT_LOCK];
    assign link_align_rotate_int_en = en_second_ff[`DIE_BIT_ROTATE];
    assign link_align_window_int_en = en_second_ff[`DIE_BIT_WINDOW];
    assign link_align_trip_int_en   = en_second_ff[`DIE_BIT_TRIP];

    // Enables of the first status byte
    always @* begin
        en_first_vec                    = 8'h00;
        en_first_vec[`DIE_BIT_DLYBUF]   = delay_buffer_int_en;
        en_first_vec[`DIE_BIT_DATARDY]  = data_ready_int_en;
        en_first_vec[`DIE_BIT_OVERFLOW] = datapath_overflow_int_en;
        en_first_vec[`DIE_BIT_QPRBS]    = q_prbs_int_en;
        en_first_vec[`DIE_BIT_IPRBS]    = i_prbs_int_en;
    end

    // Enables of the second status byte; reserved 6:5 stay zero
    always @* begin
        en_second_vec                    = 8'h00;
        en_second_vec[`DIE_BIT_PWRDET]   = power_detect_err_int_en;
        en_second_vec[`DIE_BIT_OSCALIGN] = osc_align_int_en;
        en_second_vec[`DIE_BIT_LOCK]     = link_align_lock_int_en;
        en_second_vec[`DIE_BIT_ROTATE]   = link_align_rotate_int_en;
        en_second_vec[`DIE_BIT_WINDOW]   = link_align_window_int_en;
        en_second_vec[`DIE_BIT_TRIP]     = link_align_trip_int_en;
    end

    // Live conditions of the first byte; unused positions read zero
    always @* begin
        live_first                    = 8'h00;
        live_first[`DIE_BIT_DLYBUF]   = delay_buffer_evt_i;
        live_first[`DIE_BIT_DATARDY]  = data_ready_evt_i;
        live_first[`DIE_BIT_OVERFLOW] = datapath_overflow_evt_i;
        live_first[`DIE_BIT_QPRBS]    = q_prbs_evt_i;
        live_first[`DIE_BIT_IPRBS]    = i_prbs_evt_i;
    end

    // Live conditions of the second byte; reserved 6:5 never driven
    always @* begin
        live_second                    = 8'h00;
        live_second[`DIE_BIT_PWRDET]   = power_detect_err_evt_i;
        live_second[`DIE_BIT_OSCALIGN] = osc_align_evt_i;
        live_second[`DIE_BIT_LOCK]     = link_align_lock_evt_i;
        live_second[`DIE_BIT_ROTATE]   = link_align_rotate_evt_i;
        live_second[`DIE_BIT_WINDOW]   = link_align_window_evt_i;
        live_second[`DIE_BIT_TRIP]     = link_align_tripped_i;
    end

    // Sixteen cells, second register in the upper byte
    assign en_all   = {en_second_vec, en_first_vec};
    assign live_all = {live_second, live_first};

    // Write one to a status bit clears its latch
    assign clr_all = {{8{wr_st2}} & reg_wdata_i,
                      {8{wr_st1}} & reg_wdata_i};

    ////////////////////////////////////////////////////////////////////////
    // One cell per status bit; unserved bits have enable and live at zero
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_evt
            die_event_cell u_cell (
                .clk_sys_i (clk_sys_i),
                .resetn_i  (resetn_i),
                .enable_i  (en_all[gi]),
                .live_i    (live_all[gi]),
                .clear_i   (clr_all[gi]),
                .status_o  (status_all[gi]),
                .latched_o (latched_all[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered so the read port comes from a flop
    always @* begin
        case (reg_addr_i)
            `DIE_ADDR_EN_FIRST:  nxt_rdata = en_first_ff;
            `DIE_ADDR_EN_SECOND: nxt_rdata = en_second_ff;
            `DIE_ADDR_ST_FIRST:  nxt_rdata = status_all[7:0];
            `DIE_ADDR_ST_SECOND: nxt_rdata = status_all[15:8];
            default:             nxt_rdata = 8'h00;
        endcase
    end

    // Masking with the enables lets a disable release the pin at the very
    // next edge instead of waiting one more cycle for the latch to drop
    assign irq_any = |(latched_all & en_all);

    // Interrupt: registered; any latch whose enable is still set pulls low
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
            irq_n_ff <= 1'b1;
        end else begin
            rdata_ff <= nxt_rdata;
            irq_n_ff <= ~irq_any;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign irq_n_o     = irq_n_ff;

endmodule // die_irq_enable

`default_nettype wire

// [die_irq_enable_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "die_regs.vh"
// Watches the register port and the interrupt pin only
module die_irq_chk (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    // Register port and interrupt
    input wire logic [12:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        irq_n_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////////////////
property p_rsv; $past(reg_addr_i) == `DIE_ADDR_EN_SECOND
    |-> reg_rdata_o[6:5] == 2'h0; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bits set");
property p_unm; !($past(reg_addr_i) inside {`DIE_ADDR_EN_FIRST,
    `DIE_ADDR_EN_SECOND, `DIE_ADDR_ST_FIRST, `DIE_ADDR_ST_SECOND})
    |-> reg_rdata_o == 8'h00; endproperty
a_unm: assert property (p_unm) else $error("unmapped not zero");
property p_st1; $past(reg_addr_i) == `DIE_ADDR_ST_FIRST
    |-> (reg_rdata_o & ~`DIE_ST_FIRST_MASK) == 8'h00; endproperty
a_st1: assert property (p_st1) else $error("status one spare bit");
property p_st2; $past(reg_addr_i) == `DIE_ADDR_ST_SECOND
    |-> (reg_rdata_o & ~`DIE_ST_SECOND_MASK) == 8'h00; endproperty
a_st2: assert property (p_st2) else $error("status two spare bit");
// Readback two edges after a write, address held meanwhile
property p_en1; $past(reg_wr_i, 2) && !$past(reg_wr_i) &&
    $past(reg_addr_i, 2) == `DIE_ADDR_EN_FIRST &&
    $past(reg_addr_i) == `DIE_ADDR_EN_FIRST
    |-> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
a_en1: assert property (p_en1) else $error("enable one readback");
property p_en2; $past(reg_wr_i, 2) && !$past(reg_wr_i) &&
    $past(reg_addr_i, 2) == `DIE_ADDR_EN_SECOND &&
    $past(reg_addr_i) == `DIE_ADDR_EN_SECOND
    |-> reg_rdata_o == ($past(reg_wdata_i, 2) & `DIE_EN_SECOND_MASK);
endproperty
a_en2: assert property (p_en2) else $error("enable two readback");
// Only a write can release a latched interrupt
property p_rise; $rose(irq_n_o) |-> $past(reg_wr_i, 2); endproperty
a_rise: assert property (p_rise) else $error("irq released alone");
property p_hold; !irq_n_o && !reg_wr_i && !$past(reg_wr_i)
    |=> !irq_n_o; endproperty
a_hold: assert property (p_hold) else $error("irq dropped early");
endmodule // die_irq_chk
bind die_irq_enable die_irq_chk u_chk (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rdata_o(reg_rdata_o), .irq_n_o(irq_n_o));
`default_nettype wire

// [die_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host counts interrupt requests; pin sampled on the system clock
module die_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       irq_n_i,
    output logic      [7:0] irq_cnt_o
);
logic irq_d_ff;
always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
        irq_d_ff  <= 1'b1;
        irq_cnt_o <= 8'h00;
    end else begin
        irq_d_ff <= irq_n_i;
        if (irq_d_ff && !irq_n_i) irq_cnt_o <= irq_cnt_o + 8'h01;
    end
end
endmodule // die_host_model
`default_nettype wire

// [tb_die_irq_enable.sv]
`timescale 1ns/1ps
`default_nettype none
`include "die_regs.vh"
module tb_die_irq_enable;
logic clk_sys_i = 0, resetn_i = 0, reg_wr_i = 0;
logic [12:0] reg_addr_i = 0, a, s;
logic [7:0]  reg_wdata_i = 0, reg_rdata_o, cnt, m;
logic [10:0] ev = 0;
wire         irq_n_o;
int          num_errors = 0, num_checks = 0;
// Event bit inside its byte; rows 0..4 first register, rest second
logic [2:0]  pos [11] = '{3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h7, 3'h4,
                          3'h3, 3'h2, 3'h1, 3'h0};
always #50 clk_sys_i = ~clk_sys_i;
die_irq_enable DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
    .delay_buffer_evt_i(ev[0]), .data_ready_evt_i(ev[1]),
    .datapath_overflow_evt_i(ev[2]), .q_prbs_evt_i(ev[3]),
    .i_prbs_evt_i(ev[4]), .power_detect_err_evt_i(ev[5]),
    .osc_align_evt_i(ev[6]), .link_align_lock_evt_i(ev[7]),
    .link_align_rotate_evt_i(ev[8]), .link_align_window_evt_i(ev[9]),
    .link_align_tripped_i(ev[10]), .irq_n_o(irq_n_o));
die_host_model u_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .irq_n_i(irq_n_o), .irq_cnt_o(cnt));
////////////////////////////////////////////////////////////////////////////
task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask
// Strobe lasts exactly one edge, so each call is a single write
task wr(input logic [12:0] ad, input logic [7:0] d);
    @(negedge clk_sys_i); reg_addr_i = ad; reg_wdata_i = d; reg_wr_i = 1;
    @(negedge clk_sys_i); reg_wr_i = 0;
endtask
task rdc(input string n, input logic [12:0] ad, input logic [7:0] e);
    @(negedge clk_sys_i); reg_addr_i = ad;
    @(negedge clk_sys_i); chk(n, e, reg_rdata_o);
endtask
task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
// Rows: event index gives enable/status address and bit; loop then cases
initial begin
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i) resetn_i = 1;
    for (int i = 0; i < 11; i++) begin
        a = (i < 5) ? `DIE_ADDR_EN_FIRST : `DIE_ADDR_EN_SECOND;
        s = (i < 5) ? `DIE_ADDR_ST_FIRST : `DIE_ADDR_ST_SECOND;
        m = 8'h01 << pos[i];
        wr(a, m);
        @(negedge clk_sys_i) ev[i] = 1;
        // One-cycle pulse, so the read below must come from the latch
        @(negedge clk_sys_i) ev[i] = 0;
        rdc("status latched", s, m);
        chk("irq low", 8'h00, {7'h0, irq_n_o});
        wr(s, m);
        @(negedge clk_sys_i) chk("irq high", 8'h01, {7'h0, irq_n_o});
        ev[i] = 0;
        wr(a, 8'h00);
    end
    chk("host count", 8'h0B, cnt);
    $display("event rows done");
    ev[1:0] = 2'h3;
    rdc("live view", `DIE_ADDR_ST_FIRST, 8'h30);
    chk("irq idle", 8'h01, {7'h0, irq_n_o});
    ev = 0;
    rdc("live off", `DIE_ADDR_ST_FIRST, 8'h00);
    ev[10:5] = 6'h3F;
    rdc("live view two", `DIE_ADDR_ST_SECOND, 8'h9F);
    chk("irq idle two", 8'h01, {7'h0, irq_n_o});
    ev = 0;
    $display("live views done");
    wr(`DIE_ADDR_EN_SECOND, 8'hFF);
    rdc("enable two", `DIE_ADDR_EN_SECOND, 8'h9F);
    wr(13'h030, 8'hFF);
    rdc("unmapped", 13'h030, 8'h00);
    wr(`DIE_ADDR_EN_FIRST, 8'hFF);
    rdc("enable one", `DIE_ADDR_EN_FIRST, 8'hFF);
    // Set beats a write-one clear landing on the same edge
    @(negedge clk_sys_i);
    ev[1]       = 1;
    reg_addr_i  = `DIE_ADDR_ST_FIRST;
    reg_wdata_i = 8'h10;
    reg_wr_i    = 1;
    @(negedge clk_sys_i);
    reg_wr_i    = 0;
    ev[1]       = 0;
    rdc("set wins", `DIE_ADDR_ST_FIRST, 8'h10);
    chk("irq set wins", 8'h00, {7'h0, irq_n_o});
    wr(`DIE_ADDR_ST_FIRST, 8'h10);
    // An event already high when enabled needs a fresh rising edge
    wr(`DIE_ADDR_EN_FIRST, 8'h00);
    ev[1] = 1;
    wr(`DIE_ADDR_EN_FIRST, 8'h10);
    rdc("no stale latch", `DIE_ADDR_ST_FIRST, 8'h00);
    chk("irq stale", 8'h01, {7'h0, irq_n_o});
    ev[1] = 0;
    // Leave a latched event pending across the reset below
    @(negedge clk_sys_i) ev[5] = 1;
    @(negedge clk_sys_i) ev[5] = 0;
    @(negedge clk_sys_i) chk("irq pending", 8'h00, {7'h0, irq_n_o});
    $display("awkward cases done");
    @(negedge clk_sys_i) resetn_i = 0;
    @(negedge clk_sys_i) resetn_i = 1;
    chk("irq after reset", 8'h01, {7'h0, irq_n_o});
    rdc("enable two reset", `DIE_ADDR_EN_SECOND, 8'h00);
    rdc("enable one reset", `DIE_ADDR_EN_FIRST, 8'h00);
    rdc("status reset", `DIE_ADDR_ST_SECOND, 8'h00);
    $display("register map done");
    tally_and_finish();
end
endmodule // tb_die_irq_enable
`default_nettype wire
